// File: hw/ppm_consts.svh
// Purpose: Offsets, register indices, reset values and thresholds of the pin mux
// Assumes: Word index = Avalon byte address / 4
// Notes: Definitions only
`ifndef PPM_CONSTS_SVH
`define PPM_CONSTS_SVH
`define PPM_GRP_P1 2'h0
`define PPM_GRP_P2 2'h1
`define PPM_A_CTRL 5'h10
`define PPM_A_IST 5'h11
`define PPM_A_ICLR 5'h12
`define PPM_A_IEN 5'h13
`define PPM_R_IN 3'h0
`define PPM_R_OUT 3'h1
`define PPM_R_DIR 3'h2
`define PPM_R_SEL 3'h3
`define PPM_R_IE 3'h4
`define PPM_R_IES 3'h5
`define PPM_R_IFG 3'h6
`define PPM_RST8 8'h00
`define PPM_RST_CAP 6'h00
`define PPM_RST_VLD 4'h0
`define PPM_RST_IRQ 2'h0
`define PPM_RST6 6'h00
`define PPM_RST_OE1 8'hFF
`define PPM_RST_OE2 6'h3F
`define PPM_LCD_HI 8'hE0
`define PPM_LCD_MID 8'hC0
`define PPM_VLD_EXT 4'hF
`define PPM_P1_HWMASK 8'hFF
`define PPM_P2_HWMASK 8'h3F
`endif

// File: hw/ppm_pkg.sv
// Purpose: Types shared by the pin mux modules
// Assumes: Nothing
// Notes: One-hot bus handshake states
package ppm_pkg;
  typedef logic [7:0] ppm_byte_t;
  typedef logic [31:0] ppm_word_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_ACK = 2'h2
  } ppm_bus_st_t;
endpackage : ppm_pkg

// File: hw/ppm_ifs.sv
// Purpose: Carriers between the pin mux core, its port banks and its bus slave
// Assumes: Single clock
// Notes: No clocking blocks
`timescale 1ns/1ps
interface ppm_port_if;
  import ppm_pkg::*;
  logic wr;
  logic [2:0] idx;
  ppm_byte_t wdata, pin_in, hw_mask;
  ppm_byte_t in_val, out, dir, sel, ie, ies, ifg;
  logic flag_evt;
  modport bank(input wr, idx, wdata, pin_in, hw_mask,
               output in_val, out, dir, sel, ie, ies, ifg, flag_evt);
  modport core(output wr, idx, wdata, pin_in, hw_mask,
               input in_val, out, dir, sel, ie, ies, ifg, flag_evt);
endinterface : ppm_port_if

interface ppm_bus_if;
  import ppm_pkg::*;
  logic wr;
  logic [4:0] addr;
  ppm_word_t wdata, rdata;
  modport slave(output wr, addr, wdata, input rdata);
  modport core(input wr, addr, wdata, output rdata);
endinterface : ppm_bus_if

// File: hw/ppm_port.sv
// Purpose: One 8-bit port bank: control bits and edge interrupt flags
// Assumes: pin_in already gated to zero where the port function is off
// Notes: Hardware flag set wins over a same-cycle software write
`timescale 1ns/1ps
`include "ppm_consts.svh"
module ppm_port (
  input wire logic ref_clk,
  input wire logic rst,
  ppm_port_if.bank p
);
  import ppm_pkg::*;
  ppm_byte_t out_q, dir_q, sel_q, ie_q, ies_q, ifg_q, in_q, hit, ifg_d;
  logic wr_out, wr_dir, wr_sel, wr_ie, wr_ies, wr_ifg;

  assign wr_out = p.wr && (p.idx == `PPM_R_OUT);
  assign wr_dir = p.wr && (p.idx == `PPM_R_DIR);
  assign wr_sel = p.wr && (p.idx == `PPM_R_SEL);
  assign wr_ie = p.wr && (p.idx == `PPM_R_IE);
  assign wr_ies = p.wr && (p.idx == `PPM_R_IES);
  assign wr_ifg = p.wr && (p.idx == `PPM_R_IFG);

  // Edge select clear: rising edge, set: falling edge
  for (genvar i = 0; i < 8; i++) begin : g_edge
    assign hit[i] = ie_q[i] & p.hw_mask[i] &
                    (ies_q[i] ? (in_q[i] & ~p.pin_in[i]) : (~in_q[i] & p.pin_in[i])); // R13
  end
  // Masked bits have no hardware source, so only software moves them
  assign ifg_d = (wr_ifg ? p.wdata : ifg_q) | hit; // R11

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      out_q <= `PPM_RST8;
      dir_q <= `PPM_RST8;
      sel_q <= `PPM_RST8;
      ie_q <= `PPM_RST8;
      ies_q <= `PPM_RST8;
      ifg_q <= `PPM_RST8;
      in_q <= `PPM_RST8;
    end else begin
      if (wr_out) out_q <= p.wdata;
      if (wr_dir) dir_q <= p.wdata;
      if (wr_sel) sel_q <= p.wdata;
      if (wr_ie) ie_q <= p.wdata;
      if (wr_ies) ies_q <= p.wdata;
      ifg_q <= ifg_d;
      in_q <= p.pin_in;
    end
  end

  assign p.in_val = in_q;
  assign p.out = out_q;
  assign p.dir = dir_q;
  assign p.sel = sel_q;
  assign p.ie = ie_q;
  assign p.ies = ies_q;
  assign p.ifg = ifg_q;
  assign p.flag_evt = |hit;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  flag_cause_a: assert property (!wr_ifg |=> ((ifg_q & ~$past(ifg_q)) & ~$past(hit)) == 8'h00) // R13
    else $error("flag set without edge or write");
  flag_edge_a: assert property ((hit != 8'h00) |=> (ifg_q & $past(hit)) == $past(hit)) // R13
    else $error("edge did not set its flag");
endmodule : ppm_port

// File: hw/ppm_avs.sv
// Purpose: Avalon-MM slave front end with waitrequest
// Assumes: Master holds its request until it sees waitrequest low
// Notes: Every access is answered on the second edge, unmapped reads give zero
`timescale 1ns/1ps
module ppm_avs (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [6:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire ppm_pkg::ppm_word_t avs_writedata,
  output ppm_pkg::ppm_word_t avs_readdata,
  output logic avs_waitrequest,
  ppm_bus_if.slave b
);
  import ppm_pkg::*;
  ppm_bus_st_t st_q, st_d;
  logic req;

  assign req = avs_read | avs_write;
  assign b.wr = avs_write && (st_q == ST_ACK);
  assign b.addr = avs_address[6:2];
  assign b.wdata = avs_writedata;

  always_comb begin
    case (st_q)
      ST_IDLE: st_d = req ? ST_ACK : ST_IDLE;
      ST_ACK: st_d = ST_IDLE;
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q <= ST_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      st_q <= st_d;
      avs_waitrequest <= (st_d != ST_ACK);
      if (st_d == ST_ACK) avs_readdata <= b.rdata;
    end
  end

  sequence s_req;
    req && avs_waitrequest && (st_q == ST_IDLE);
  endsequence
  sequence s_ack;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  bus_ack_a: assert property (@(posedge ref_clk) disable iff (rst) s_req |=> s_ack)
    else $error("bus request not answered in one cycle");
endmodule : ppm_avs

// File: hw/ppm_top.sv
// Purpose: Pin multiplexer for two 8-bit ports with LCD and analog hand-over
// Assumes: Pin and peripheral inputs are synchronous to ref_clk
// Notes: Pin and peripheral outputs are registered, one cycle behind their cause
// What this block does
// [R01] Pins 1.0,1.1,2.2-2.5 digital while analog disable clear
// [R02] LCD-capable pins are ports only when selection zero
// [R03] Pins 1.2-1.5 go LCD at mode E0h
// [R04] Pins 1.6-1.7 go LCD at mode C0h
// [R05] Pins 2.0-2.1 go LCD at mode E0h
// [R06] Serial direction controls steer pins 1.6,1.7,2.1
// [R07] 2.4 forced transmit output; 2.2,2.5 forced inputs
// [R08] Pin 1.1 outputs main clock, feeds capture 0B
// [R09] Pin 1.5 outputs auxiliary clock, feeds timer clock
// [R10] Pin 2.3 analog when supervisor level is 1111b
// [R11] Unbonded port 2 bits 6,7 are software flags
// [R12] Pin 1.3 supervisor output; 1.0 compare/capture 0A
// [R13] Port mode: direction drives output; edges set flags
`timescale 1ns/1ps
`include "ppm_consts.svh"
module ppm_top (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [6:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire ppm_pkg::ppm_word_t avs_writedata,
  output ppm_pkg::ppm_word_t avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  input wire ppm_pkg::ppm_byte_t p1_pin_in,
  output ppm_pkg::ppm_byte_t p1_pin_out,
  output ppm_pkg::ppm_byte_t p1_pin_oe_n,
  input wire logic [5:0] p2_pin_in,
  output logic [5:0] p2_pin_out,
  output logic [5:0] p2_pin_oe_n,
  input wire ppm_pkg::ppm_byte_t lcd_seg,
  input wire logic timer_out0,
  input wire logic timer_out1,
  input wire logic timer_out2,
  input wire logic mclk_sig,
  input wire logic aclk_sig,
  input wire logic supervisor_comparator_output,
  input wire logic spi_simo_out,
  input wire logic spi_somi_out,
  input wire logic spi_uclk_out,
  input wire logic serial_transmit_data,
  input wire logic serial_slave_in_direction_control,
  input wire logic serial_slave_out_direction_control,
  input wire logic serial_clock_direction_control,
  output logic timer_capture_input_0_a,
  output logic timer_capture_input_0_b,
  output logic timer_capture_input_1_a,
  output logic timer_capture_input_2_a,
  output logic timer_external_clock_input,
  output logic serial_slave_enable_input,
  output logic serial_receive_data,
  output logic spi_simo_in,
  output logic spi_somi_in,
  output logic spi_uclk_in
);
  import ppm_pkg::*;

  // Returns {oe_n, out}; LCD beats analog beats function select
  function automatic logic [1:0] pin_drive(input logic s, input logic o, input logic d,
                                           input logic mo, input logic md, input logic lcd,
                                           input logic seg, input logic an);
    if (lcd) pin_drive = {1'b0, seg};
    else if (an) pin_drive = 2'h2;
    else if (s) pin_drive = {~md, mo};
    else pin_drive = {~d, o};
  endfunction : pin_drive

  function automatic ppm_byte_t port_rd(input logic [2:0] idx, input ppm_byte_t i,
                                        input ppm_byte_t o, input ppm_byte_t d,
                                        input ppm_byte_t s, input ppm_byte_t e,
                                        input ppm_byte_t es, input ppm_byte_t f);
    case (idx)
      `PPM_R_IN: port_rd = i;
      `PPM_R_OUT: port_rd = o;
      `PPM_R_DIR: port_rd = d;
      `PPM_R_SEL: port_rd = s;
      `PPM_R_IE: port_rd = e;
      `PPM_R_IES: port_rd = es;
      `PPM_R_IFG: port_rd = f;
      default: port_rd = `PPM_RST8;
    endcase
  endfunction : port_rd

  ppm_bus_if bus();
  ppm_port_if pi1();
  ppm_port_if pi2();

  logic [5:0] cap_q;
  ppm_byte_t lcd_mode_field_q;
  logic [3:0] vld_q;
  logic [1:0] ist_q, ien_q, ist_d, evt;
  logic lcd_hi, lcd_mid, vld_ext;
  logic ctrl_wr, iclr_wr, ien_wr;
  logic [1:0] grp;
  ppm_byte_t p1_lcd, p2_lcd, p1_an, p2_an, p1_seg, p2_seg;
  ppm_byte_t p1_din, p2_din, p1_mi, p2_mi;
  ppm_byte_t p1_mo, p1_md, p2_mo, p2_md;
  ppm_byte_t p1_out_d, p1_oe_n_d, p2_out_d, p2_oe_n_d;
  ppm_byte_t p1_rd, p2_rd;
  ppm_word_t ctl_rd;

  ppm_avs u_avs (
    .ref_clk(ref_clk),
    .rst(rst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .b(bus.slave)
  );

  ppm_port u_p1 (
    .ref_clk(ref_clk),
    .rst(rst),
    .p(pi1.bank)
  );

  ppm_port u_p2 (
    .ref_clk(ref_clk),
    .rst(rst),
    .p(pi2.bank)
  );

  // Address decode
  assign grp = bus.addr[4:3];
  assign ctrl_wr = bus.wr && (bus.addr == `PPM_A_CTRL);
  assign iclr_wr = bus.wr && (bus.addr == `PPM_A_ICLR);
  assign ien_wr = bus.wr && (bus.addr == `PPM_A_IEN);
  assign pi1.wr = bus.wr && (grp == `PPM_GRP_P1);
  assign pi2.wr = bus.wr && (grp == `PPM_GRP_P2);
  assign pi1.idx = bus.addr[2:0];
  assign pi2.idx = bus.addr[2:0];
  assign pi1.wdata = bus.wdata[7:0];
  assign pi2.wdata = bus.wdata[7:0];
  assign pi1.hw_mask = `PPM_P1_HWMASK;
  assign pi2.hw_mask = `PPM_P2_HWMASK; // R11

  // Hand-over conditions
  assign lcd_hi = lcd_mode_field_q >= `PPM_LCD_HI;
  assign lcd_mid = lcd_mode_field_q >= `PPM_LCD_MID;
  assign vld_ext = vld_q == `PPM_VLD_EXT;
  assign p1_lcd = {{2{lcd_mid}}, {4{lcd_hi}}, 2'h0}; // R02 R03 R04
  assign p2_lcd = {6'h00, {2{lcd_hi}}}; // R02 R05
  assign p1_an = {6'h00, cap_q[1:0]}; // R01
  assign p2_an = {2'h0, cap_q[5:4], cap_q[3] | vld_ext, cap_q[2], 2'h0}; // R01 R10
  assign p1_seg = {lcd_seg[5:0], 2'h0};
  assign p2_seg = {6'h00, lcd_seg[7:6]};

  // Input buffers off while the pin is LCD or analog; no pins behind bits 6,7
  assign p1_din = p1_pin_in & ~(p1_lcd | p1_an); // R01 R02
  assign p2_din = {2'h0, p2_pin_in} & ~(p2_lcd | p2_an); // R10 R11
  assign pi1.pin_in = p1_din;
  assign pi2.pin_in = p2_din;
  assign p1_mi = p1_din & pi1.sel;
  assign p2_mi = p2_din & pi2.sel;

  // Peripheral function sources
  assign p1_mo = {spi_somi_out, spi_simo_out, aclk_sig, 1'b0, supervisor_comparator_output,
                  timer_out1, mclk_sig, timer_out0}; // R08 R09 R12
  assign p1_md = {serial_slave_out_direction_control, serial_slave_in_direction_control,
                  pi1.dir[5:0]}; // R06
  // Transmit data belongs on pin 2.4; pins 2.2, 2.3 and 2.5 have no module output
  assign p2_mo = {3'h0, serial_transmit_data, 2'h0, spi_uclk_out, timer_out2}; // R07
  assign p2_md = {pi2.dir[7:6], 1'b0, 1'b1, pi2.dir[3], 1'b0,
                  serial_clock_direction_control, pi2.dir[0]}; // R06 R07

  for (genvar i = 0; i < 8; i++) begin : g_pin
    assign {p1_oe_n_d[i], p1_out_d[i]} = pin_drive(pi1.sel[i], pi1.out[i], pi1.dir[i],
        p1_mo[i], p1_md[i], p1_lcd[i], p1_seg[i], p1_an[i]); // R13
    assign {p2_oe_n_d[i], p2_out_d[i]} = pin_drive(pi2.sel[i], pi2.out[i], pi2.dir[i],
        p2_mo[i], p2_md[i], p2_lcd[i], p2_seg[i], p2_an[i]); // R13
  end

  // Read mux; unmapped words read zero
  assign p1_rd = port_rd(pi1.idx, pi1.in_val, pi1.out, pi1.dir, pi1.sel, pi1.ie, pi1.ies,
                         pi1.ifg);
  assign p2_rd = port_rd(pi2.idx, pi2.in_val, pi2.out, pi2.dir, pi2.sel, pi2.ie, pi2.ies,
                         pi2.ifg);
  assign ctl_rd = (bus.addr == `PPM_A_CTRL) ? {12'h000, vld_q, lcd_mode_field_q, 2'h0, cap_q} :
                  (bus.addr == `PPM_A_IST) ? {30'h00000000, ist_q} :
                  (bus.addr == `PPM_A_IEN) ? {30'h00000000, ien_q} : 32'h00000000;
  assign bus.rdata = (grp == `PPM_GRP_P1) ? {24'h000000, p1_rd} :
                     (grp == `PPM_GRP_P2) ? {24'h000000, p2_rd} : ctl_rd;

  // Sticky status; a new event beats a same-cycle clear
  assign evt = {pi2.flag_evt, pi1.flag_evt};
  assign ist_d = (ist_q & ~(iclr_wr ? bus.wdata[1:0] : 2'h0)) | evt;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cap_q <= `PPM_RST_CAP;
      lcd_mode_field_q <= `PPM_RST8;
      vld_q <= `PPM_RST_VLD;
    end else if (ctrl_wr) begin
      cap_q <= bus.wdata[5:0];
      lcd_mode_field_q <= bus.wdata[15:8];
      vld_q <= bus.wdata[19:16];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ist_q <= `PPM_RST_IRQ;
      ien_q <= `PPM_RST_IRQ;
      irq <= 1'b0;
    end else begin
      ist_q <= ist_d;
      if (ien_wr) ien_q <= bus.wdata[1:0];
      irq <= |(ist_q & ien_q);
    end
  end

  // Pins; bits 6,7 of port 2 are never bonded out
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      p1_pin_out <= `PPM_RST8;
      p1_pin_oe_n <= `PPM_RST_OE1;
      p2_pin_out <= `PPM_RST6;
      p2_pin_oe_n <= `PPM_RST_OE2;
    end else begin
      p1_pin_out <= p1_out_d;
      p1_pin_oe_n <= p1_oe_n_d;
      p2_pin_out <= p2_out_d[5:0];
      p2_pin_oe_n <= p2_oe_n_d[5:0];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      timer_capture_input_0_a <= 1'b0;
      timer_capture_input_0_b <= 1'b0;
      timer_capture_input_1_a <= 1'b0;
      timer_capture_input_2_a <= 1'b0;
      timer_external_clock_input <= 1'b0;
      serial_slave_enable_input <= 1'b0;
      serial_receive_data <= 1'b0;
      spi_simo_in <= 1'b0;
      spi_somi_in <= 1'b0;
      spi_uclk_in <= 1'b0;
    end else begin
      timer_capture_input_0_a <= p1_mi[0]; // R12
      timer_capture_input_0_b <= p1_mi[1]; // R08
      timer_capture_input_1_a <= p1_mi[2];
      timer_external_clock_input <= p1_mi[5]; // R09
      spi_simo_in <= p1_mi[6];
      spi_somi_in <= p1_mi[7];
      timer_capture_input_2_a <= p2_mi[0];
      spi_uclk_in <= p2_mi[1];
      serial_slave_enable_input <= p2_mi[2]; // R07
      serial_receive_data <= p2_mi[5]; // R07
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_sel14;
    pi1.sel[4] == 1'b0 && pi1.dir[4] && !lcd_hi;
  endsequence
  analog_off_a: assert property (cap_q[0] |=> p1_pin_oe_n[0] && !timer_capture_input_0_a) // R01
    else $error("analog pin still digital");
  lcd_sel_a: assert property (lcd_mid && !lcd_hi |=> p1_pin_oe_n[7:6] == 2'h0) // R02
    else $error("LCD pin not driven");
  lcd_hi_a: assert property (lcd_hi |=> p1_pin_out[5:2] == $past(lcd_seg[3:0])) // R03
    else $error("segment missing on port 1 low group");
  lcd_mid_a: assert property (lcd_mid |=> p1_pin_out[7:6] == $past(lcd_seg[5:4])) // R04
    else $error("segment missing on port 1 high group");
  lcd_p2_a: assert property (lcd_hi |=> p2_pin_out[1:0] == $past(lcd_seg[7:6])) // R05
    else $error("segment missing on port 2");
  port_keep_a: assert property (s_sel14 |=> !p1_pin_oe_n[4] && p1_pin_out[4] == $past(pi1.out[4])) // R13
    else $error("port pin not driven from its output bit");
  spi_dir_a: assert property (pi1.sel[6] && !lcd_mid
                              |=> p1_pin_oe_n[6] == !$past(serial_slave_in_direction_control)) // R06
    else $error("serial direction ignored");
  txd_out_a: assert property (pi2.sel[4] && !cap_q[4]
                              |=> !p2_pin_oe_n[4] && p2_pin_out[4] == $past(serial_transmit_data)) // R07
    else $error("transmit pin not forced out");
  rxd_in_a: assert property (pi2.sel[5] |=> p2_pin_oe_n[5]) // R07
    else $error("receive pin not forced in");
  mclk_out_a: assert property (pi1.sel[1] && !cap_q[1] |=> p1_pin_out[1] == $past(mclk_sig)) // R08
    else $error("main clock not on pin");
  aclk_out_a: assert property (pi1.sel[5] && !lcd_hi |=> p1_pin_out[5] == $past(aclk_sig)) // R09
    else $error("auxiliary clock not on pin");
  vld_analog_a: assert property (vld_ext |=> p2_pin_oe_n[3]) // R10
    else $error("pin 2.3 digital in analog mode");
  soft_flag_a: assert property (!(pi2.wr && pi2.idx == `PPM_R_IFG)
                                |=> pi2.ifg[7:6] == $past(pi2.ifg[7:6])) // R11
    else $error("software flag moved without a write");
  svs_out_a: assert property (pi1.sel[3] && !lcd_hi
                              |=> p1_pin_out[3] == $past(supervisor_comparator_output)) // R12
    else $error("supervisor output not on pin");
  irq_level_a: assert property ((ist_q & ien_q) != 2'h0 |=> irq) // R13
    else $error("interrupt not raised");
endmodule : ppm_top

// File: tb/ppm_pin_model.sv
// Purpose: External circuitry on the package pins of both ports
// Assumes: Sources sit behind series resistors, so a pin the device drives wins
// Notes: Each wire level is resolved from the device output enables
`timescale 1ns/1ps
module ppm_pin_model (
  input wire logic [7:0] p1_out,
  input wire logic [7:0] p1_oe_n,
  input wire logic [5:0] p2_out,
  input wire logic [5:0] p2_oe_n,
  input wire logic [13:0] ext_val,
  output logic [7:0] p1_lvl,
  output logic [5:0] p2_lvl
);
  // Low enable means the device drives the wire
  assign p1_lvl = (p1_out & ~p1_oe_n) | (ext_val[7:0] & p1_oe_n);
  assign p2_lvl = (p2_out & ~p2_oe_n) | (ext_val[13:8] & p2_oe_n);
endmodule : ppm_pin_model

// File: tb/tb_port_pin_function_mux.sv
// Purpose: Self-checking bench for the pin mux
// Assumes: Bus answer comes when waitrequest drops; pins settle in two cycles
// Notes: Seeded random stimulus plus fixed LCD, analog and flag corners
`timescale 1ns/1ps
`include "ppm_consts.svh"
module tb_port_pin_function_mux;
  import ppm_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [6:0] avs_address = 7'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  ppm_word_t avs_writedata = 32'h0;
  ppm_word_t avs_readdata, q, r;
  logic avs_waitrequest, irq;
  ppm_byte_t p1_pin_in, p1_pin_out, p1_pin_oe_n;
  ppm_byte_t lcd_seg = 8'h00;
  logic [5:0] p2_pin_in, p2_pin_out, p2_pin_oe_n;
  logic [12:0] perif = 13'h0000;
  logic [13:0] ext_val = 14'h0000;
  logic [13:0] ov, dv, lv;
  wire [9:0] cap;
  int miscompares = 0;
  int n_checks = 0;
  int seed = 45;
  logic [4:0] zl [0:11] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h0E, 5'h10,
                            5'h11, 5'h13, 5'h07, 5'h1F};
  ppm_byte_t modes [0:4] = '{8'hBF, 8'hC0, 8'hDF, 8'hE0, 8'hFF};

  always #4 ref_clk = ~ref_clk;

  ppm_top u_dut (
    .ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .p1_pin_in(p1_pin_in),
    .p1_pin_out(p1_pin_out), .p1_pin_oe_n(p1_pin_oe_n), .p2_pin_in(p2_pin_in),
    .p2_pin_out(p2_pin_out), .p2_pin_oe_n(p2_pin_oe_n), .lcd_seg(lcd_seg),
    .timer_out0(perif[0]), .timer_out1(perif[1]), .timer_out2(perif[2]),
    .mclk_sig(perif[3]), .aclk_sig(perif[4]), .supervisor_comparator_output(perif[5]),
    .spi_simo_out(perif[6]), .spi_somi_out(perif[7]), .spi_uclk_out(perif[8]),
    .serial_transmit_data(perif[9]), .serial_slave_in_direction_control(perif[10]),
    .serial_slave_out_direction_control(perif[11]),
    .serial_clock_direction_control(perif[12]),
    .timer_capture_input_0_a(cap[9]), .timer_capture_input_0_b(cap[8]),
    .timer_capture_input_1_a(cap[7]), .timer_capture_input_2_a(cap[6]),
    .timer_external_clock_input(cap[5]), .serial_slave_enable_input(cap[4]),
    .serial_receive_data(cap[3]), .spi_simo_in(cap[2]), .spi_somi_in(cap[1]),
    .spi_uclk_in(cap[0]));

  ppm_pin_model u_pins (
    .p1_out(p1_pin_out), .p1_oe_n(p1_pin_oe_n), .p2_out(p2_pin_out),
    .p2_oe_n(p2_pin_oe_n), .ext_val(ext_val), .p1_lvl(p1_pin_in), .p2_lvl(p2_pin_in));

  // Pins in segment use, bits 9:8 port 2, 7:0 port 1
  function automatic logic [13:0] lcd_map(input ppm_byte_t m);
    lcd_map = {4'h0, {2{m >= `PPM_LCD_HI}}, {2{m >= `PPM_LCD_MID}}, {4{m >= `PPM_LCD_HI}}, 2'b00};
  endfunction : lcd_map

  // Function mode with every direction bit set
  function automatic logic [13:0] fn_oe(input logic [12:0] p);
    fn_oe = {4'b1001, ~p[12], 1'b0, ~p[11], ~p[10], 6'h00};
  endfunction : fn_oe

  function automatic logic [13:0] fn_out(input logic [12:0] p);
    fn_out = {1'b0, p[9], 2'b00, p[8], p[2], p[7], p[6], p[4], 1'b0, p[5], p[1], p[3], p[0]};
  endfunction : fn_out

  function automatic logic [9:0] fn_cap(input logic [13:0] w);
    fn_cap = {w[0], w[1], w[2], w[8], w[5], w[10], w[13], w[6], w[7], w[9]};
  endfunction : fn_cap

  task automatic finish_test();
    if (miscompares == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input ppm_word_t seen, input ppm_word_t exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc

  // Request held until waitrequest is sampled low
  task automatic bus_wr(input logic [4:0] a, input ppm_word_t wd);
    @(posedge ref_clk);
    avs_address <= {a, 2'b00};
    avs_writedata <= wd;
    avs_write <= 1'b1;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [4:0] a, output ppm_word_t rd);
    @(posedge ref_clk);
    avs_address <= {a, 2'b00};
    avs_read <= 1'b1;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
  endtask : bus_rd

  task automatic wr2(input logic [2:0] ri, input ppm_byte_t d1, input ppm_byte_t d2);
    bus_wr({`PPM_GRP_P1, ri}, {24'h0, d1});
    bus_wr({`PPM_GRP_P2, ri}, {24'h0, d2});
  endtask : wr2

  task automatic pins(input logic [13:0] eo, input logic [13:0] eoe);
    chk("oe_n", {18'h0, p2_pin_oe_n, p1_pin_oe_n}, {18'h0, eoe});
    chk("pin_out", {18'h0, {p2_pin_out, p1_pin_out} & ~eoe}, {18'h0, eo & ~eoe});
  endtask : pins

  // Whole run is under 400 cycles; 20000 cycles means a hang
  initial begin
    #160000;
    miscompares++;
    finish_test();
  end

  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    cyc(2);
    pins(14'h0000, 14'h3FFF);
    chk("irq_rst", 32'(irq), 32'h0);
    foreach (zl[i]) begin
      bus_rd(zl[i], q);
      chk("reg_rst", q, 32'h0);
    end
    repeat (6) begin
      r = $random(seed);
      ov = r[13:0];
      dv = r[27:14];
      ext_val <= r[31:18];
      wr2(`PPM_R_OUT, ov[7:0], {2'b00, ov[13:8]});
      wr2(`PPM_R_DIR, dv[7:0], {2'b00, dv[13:8]});
      cyc(2);
      pins(ov, ~dv);
      lv = (ov & dv) | (ext_val & ~dv);
      bus_rd({`PPM_GRP_P1, `PPM_R_IN}, q);
      chk("p1_in", q & 32'hFF, {24'h0, lv[7:0]});
      bus_rd({`PPM_GRP_P2, `PPM_R_IN}, q);
      chk("p2_in", q & 32'h3F, {26'h0, lv[13:8]});
    end
    wr2(`PPM_R_DIR, 8'h00, 8'h00);
    ext_val <= 14'h0000;
    wr2(`PPM_R_IE, 8'hFF, 8'h00);
    wr2(`PPM_R_IES, 8'h0F, 8'h00);
    wr2(`PPM_R_IFG, 8'h00, 8'h00);
    bus_wr(`PPM_A_IEN, 32'h0);
    bus_wr(`PPM_A_ICLR, 32'h3);
    ext_val <= 14'h00FF;
    cyc(3);
    bus_rd({`PPM_GRP_P1, `PPM_R_IFG}, q);
    chk("ifg_rise", q & 32'hFF, 32'hF0);
    chk("irq_masked", 32'(irq), 32'h0);
    bus_rd(`PPM_A_IST, q);
    chk("ist_set", q & 32'h3, 32'h1);
    bus_wr(`PPM_A_IEN, 32'h1);
    cyc(2);
    chk("irq_on", 32'(irq), 32'h1);
    ext_val <= 14'h0000;
    cyc(3);
    bus_rd({`PPM_GRP_P1, `PPM_R_IFG}, q);
    chk("ifg_fall", q & 32'hFF, 32'hFF);
    bus_wr(`PPM_A_ICLR, 32'h1);
    cyc(2);
    chk("irq_clr", 32'(irq), 32'h0);
    bus_rd(`PPM_A_IST, q);
    chk("ist_clr", q & 32'h3, 32'h0);
    // Unbonded bits: only the write path may move them
    wr2(`PPM_R_IE, 8'h00, 8'hFF);
    bus_wr({`PPM_GRP_P2, `PPM_R_IFG}, 32'hC0);
    ext_val <= 14'h3F00;
    cyc(3);
    ext_val <= 14'h0000;
    cyc(3);
    bus_rd({`PPM_GRP_P2, `PPM_R_IFG}, q);
    chk("sw_flag_set", q & 32'hC0, 32'hC0);
    bus_wr({`PPM_GRP_P2, `PPM_R_IFG}, 32'h00);
    bus_rd({`PPM_GRP_P2, `PPM_R_IFG}, q);
    chk("sw_flag_clr", q & 32'hC0, 32'h00);
    wr2(`PPM_R_IE, 8'h00, 8'h00);
    bus_wr(`PPM_A_ICLR, 32'h3);
    wr2(`PPM_R_DIR, 8'hFF, 8'hFF);
    wr2(`PPM_R_OUT, 8'h00, 8'h00);
    lcd_seg <= 8'hFF;
    foreach (modes[i]) begin
      bus_wr(`PPM_A_CTRL, {16'h0, modes[i], 8'h00});
      cyc(2);
      pins(lcd_map(modes[i]), 14'h0000);
    end
    wr2(`PPM_R_OUT, 8'hFF, 8'hFF);
    ext_val <= 14'h3FFF;
    bus_wr(`PPM_A_CTRL, 32'h3F);
    cyc(2);
    pins(14'h3FFF, {6'h3C, 8'h03});
    bus_rd({`PPM_GRP_P1, `PPM_R_IN}, q);
    chk("p1_in_analog", q & 32'hFF, 32'hFC);
    bus_rd({`PPM_GRP_P2, `PPM_R_IN}, q);
    chk("p2_in_analog", q & 32'h3F, 32'h03);
    bus_wr(`PPM_A_CTRL, 32'hE0000);
    cyc(2);
    pins(14'h3FFF, 14'h0000);
    bus_wr(`PPM_A_CTRL, 32'hF0000);
    cyc(2);
    pins(14'h3FFF, {6'h08, 8'h00});
    bus_rd({`PPM_GRP_P2, `PPM_R_IN}, q);
    chk("p2_in_vld", q & 32'h3F, 32'h37);
    bus_wr(`PPM_A_CTRL, 32'h0);
    wr2(`PPM_R_SEL, 8'hFF, 8'hFF);
    repeat (8) begin
      r = $random(seed);
      perif <= r[12:0];
      ext_val <= r[26:13];
      cyc(4);
      pins(fn_out(perif), fn_oe(perif));
      lv = (fn_out(perif) & ~fn_oe(perif)) | (ext_val & fn_oe(perif));
      chk("capture", {22'h0, cap}, {22'h0, fn_cap(lv)});
    end
    ext_val <= 14'h3FFF;
    wr2(`PPM_R_SEL, 8'h00, 8'h00);
    wr2(`PPM_R_DIR, 8'h00, 8'h00);
    cyc(4);
    chk("capture_off", {22'h0, cap}, 32'h0);
    finish_test();
  end
endmodule : tb_port_pin_function_mux
